// ### logic/isc_pkg.sv
// Constants, codes and register map for input scaling and output routing
package isc_pkg;

  // Clock and time base
  localparam int ISC_CLK_MHZ = 125;
  localparam int ISC_TICK_MS = 10;
  localparam int ISC_TICK_CYCLES = ISC_CLK_MHZ * 1000 * ISC_TICK_MS;
  localparam int ISC_TICKS_PER_SEC = 1000 / ISC_TICK_MS;

  // Register byte addresses
  localparam logic [7:0] ISC_A_TYPE = 8'h00;
  localparam logic [7:0] ISC_A_UNIT = 8'h04;
  localparam logic [7:0] ISC_A_SHIFT_HI = 8'h08;
  localparam logic [7:0] ISC_A_SHIFT_LO = 8'h0C;
  localparam logic [7:0] ISC_A_SCALE_HI = 8'h10;
  localparam logic [7:0] ISC_A_SCALE_LO = 8'h14;
  localparam logic [7:0] ISC_A_DECIMAL = 8'h18;
  localparam logic [7:0] ISC_A_OUT1 = 8'h1C;
  localparam logic [7:0] ISC_A_OUT2 = 8'h20;
  localparam logic [7:0] ISC_A_AUX1 = 8'h24;
  localparam logic [7:0] ISC_A_ACTION = 8'h28;
  localparam logic [7:0] ISC_A_PER_HEAT = 8'h2C;
  localparam logic [7:0] ISC_A_PER_COOL = 8'h30;
  localparam logic [7:0] ISC_A_STATUS = 8'h34;
  localparam logic [7:0] ISC_A_PV = 8'h38;

  // Input types: 0..ISC_TEMP_LAST are sensors, the rest analog
  localparam logic [4:0] ISC_TYPE_MAX = 5'h15;
  localparam logic [4:0] ISC_TEMP_LAST = 5'h10;
  localparam logic [4:0] ISC_TYPE_RST = 5'h02;

  // Output functions
  typedef enum logic [3:0] {
    ISC_FN_HEAT = 4'h0, ISC_FN_COOL = 4'h1, ISC_FN_ALM1 = 4'h2, ISC_FN_ALM2 = 4'h3,
    ISC_FN_ALM3 = 4'h4, ISC_FN_LOOP = 4'h5, ISC_FN_TSIG1 = 4'h6, ISC_FN_TSIG2 = 4'h7,
    ISC_FN_PEND = 4'h8, ISC_FN_STAGE = 4'h9, ISC_FN_ERR1 = 4'hA, ISC_FN_ERR2 = 4'hB
  } isc_fn_t;
  localparam logic [3:0] ISC_FN_LAST = 4'hB;

  // Destination masks, bit n set when function n may go there
  localparam logic [11:0] ISC_MASK_OUT1 = 12'h3FF;
  localparam logic [11:0] ISC_MASK_OUT2 = 12'h3FD;
  localparam logic [11:0] ISC_MASK_AUX1 = 12'hFFC;

  // Reset values
  localparam logic [3:0] ISC_OUT1_RST = 4'h0;
  localparam logic [3:0] ISC_OUT2_RST = 4'h2;
  localparam logic [3:0] ISC_AUX1_RST = 4'h3;
  localparam logic ISC_REVERSE_RST = 1'b1;
  localparam logic ISC_FAHR_RST = 1'b0;
  localparam logic [15:0] ISC_SHIFT_RST = 16'h0000;
  localparam logic [15:0] ISC_SCALE_HI_RST = 16'h03E8;
  localparam logic [15:0] ISC_SCALE_LO_RST = 16'h0000;
  localparam logic [1:0] ISC_DEC_RST = 2'h0;
  localparam logic [1:0] ISC_DEC_MAX = 2'h3;
  localparam logic [1:0] ISC_TEMP_DP = 2'h1;
  localparam logic [6:0] ISC_PERIOD_RST = 7'h14;
  localparam logic [6:0] ISC_PERIOD_MIN = 7'h01;
  localparam logic [6:0] ISC_PERIOD_MAX = 7'h63;
  localparam logic [6:0] ISC_MV_FULL = 7'h64;

  // Raw converter span and Fahrenheit offset in tenths
  localparam int ISC_RAW_BITS = 12;
  localparam logic signed [31:0] ISC_F_OFFSET = 32'sh0000_0140;

endpackage

// ### logic/isc_rom_if.sv
// Carrier between the controller and its sensor range table
`timescale 1ns/1ps
interface isc_rom_if;
  logic [4:0] addr;
  logic [15:0] rangeLo;
  logic [15:0] rangeHi;
  modport rom (input addr, output rangeLo, output rangeHi);
  modport user (output addr, input rangeLo, input rangeHi);
endinterface

// ### logic/isc_range_rom.sv
// Sensor range table, lower and upper limits in tenths of a degree C
`timescale 1ns/1ps
module isc_range_rom (
  // Clock
  input wire logic clk_sys,
  // Lookup
  isc_rom_if.rom port
);
  import isc_pkg::*;

  logic [15:0] loD;
  logic [15:0] hiD;

  always_comb begin
    case (port.addr)
      5'h00: begin loD = 16'hF830; hiD = 16'h3390; end
      5'h01: begin loD = 16'hF830; hiD = 16'h2710; end
      5'h02: begin loD = 16'hF830; hiD = 16'h3390; end
      5'h03: begin loD = 16'hF830; hiD = 16'h1388; end
      5'h04: begin loD = 16'hF830; hiD = 16'h0FA0; end
      5'h05: begin loD = 16'hF830; hiD = 16'h2328; end
      5'h06: begin loD = 16'hF830; hiD = 16'h0FA0; end
      5'h07: begin loD = 16'h0000; hiD = 16'h4268; end
      5'h08: begin loD = 16'h0000; hiD = 16'h4268; end
      5'h09: begin loD = 16'h0000; hiD = 16'h4650; end
      5'h0A: begin loD = 16'h0000; hiD = 16'h4650; end
      5'h0B: begin loD = 16'hF830; hiD = 16'h3390; end
      5'h0C: begin loD = 16'hF830; hiD = 16'h3390; end
      5'h0D: begin loD = 16'hF830; hiD = 16'h1388; end
      5'h0E: begin loD = 16'hF830; hiD = 16'h1388; end
      5'h0F: begin loD = 16'hF830; hiD = 16'h0FA0; end
      5'h10: begin loD = 16'h0000; hiD = 16'h0FA0; end
      default: begin loD = 16'h0000; hiD = 16'h0000; end
    endcase
  end

  // Registered read data, one cycle behind the address
  always_ff @(posedge clk_sys) begin
    port.rangeLo <= loD;
    port.rangeHi <= hiD;
  end

endmodule

// ### logic/isc_top.sv
// Input scaling, output routing and time-proportioning controller core
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// - Input type 0 to 21, default 2
// - Sensor types derive scaling, hide scale settings
// - Unit setting selects Celsius or Fahrenheit
// - Linear shift from upper and lower offsets
// - Analog input maps span onto scale limits
// - Scale and decimal locked for sensor types
// - Twelve functions routed to legal destinations only
// - Cool assigned means heating and cooling control
// - Defaults heat, alarm 1, alarm 2
// - Direct raises output with process_value; reverse default
// - Heat period in seconds, default 20
// - Cool period locked while cool unassigned
module isc_top #(
  parameter int TICK_CYCLES = isc_pkg::ISC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Converter samples and control inputs
  input wire logic rawValid,
  input wire logic [11:0] rawData,
  input wire logic [15:0] setPoint,
  input wire logic [11:2] funcIn,
  // Process value
  output logic [15:0] processValue,
  output logic pvValid,
  output logic [1:0] decimalPlaces,
  output logic fahrenheitOut,
  // Control
  output logic heatCoolMode,
  output logic [6:0] mvHeat,
  output logic [6:0] mvCool,
  output logic ctrlOut1,
  output logic ctrlOut2,
  output logic auxOut1
);
  import isc_pkg::*;

  function automatic logic [15:0] iscLerp(input logic [15:0] lo, input logic [15:0] hi,
                                          input logic [11:0] r);
    logic signed [31:0] span;
    logic signed [31:0] prod;
    span = 32'($signed(hi)) - 32'($signed(lo));
    prod = span * $signed({20'h00000, r});
    // Divide by full scale rather than shift, so the top code lands on hi exactly
    iscLerp = 16'(32'($signed(lo)) + prod / ((32'sd1 <<< ISC_RAW_BITS) - 32'sd1));
  endfunction

  function automatic logic [6:0] iscClamp(input logic signed [31:0] v);
    if (v <= 32'sh0) begin
      iscClamp = 7'h00;
    end else if (v >= 32'($signed({1'b0, ISC_MV_FULL}))) begin
      iscClamp = ISC_MV_FULL;
    end else begin
      iscClamp = 7'(v);
    end
  endfunction

  function automatic logic iscLegal(input logic [11:0] mask, input logic [31:0] code);
    iscLegal = (code <= 32'(ISC_FN_LAST)) && mask[4'(code)];
  endfunction

  // Reset release through two flops
  logic rstMeta;
  logic rstSync;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Configuration registers
  logic [4:0] inTypeQ;
  logic fahrQ;
  logic [15:0] shiftHiQ;
  logic [15:0] shiftLoQ;
  logic [15:0] scaleHiQ;
  logic [15:0] scaleLoQ;
  logic [1:0] decimalQ;
  logic [3:0] out1AssignQ;
  logic [3:0] out2AssignQ;
  logic [3:0] aux1AssignQ;
  logic reverseQ;
  logic [6:0] perHeatQ;
  logic [6:0] perCoolQ;

  isc_rom_if romBus ();
  isc_range_rom uRom (
    .clk_sys(clk_sys),
    .port(romBus.rom)
  );
  assign romBus.addr = inTypeQ;

  wire tempSel = (inTypeQ <= ISC_TEMP_LAST);
  wire heatCool = (out1AssignQ == ISC_FN_COOL) || (out2AssignQ == ISC_FN_COOL)
                  || (aux1AssignQ == ISC_FN_COOL);

  // Write decode; illegal or locked writes are dropped silently
  wire wrType = regWr && (regAddr == ISC_A_TYPE) && (regWrData <= 32'(ISC_TYPE_MAX));
  wire wrUnit = regWr && (regAddr == ISC_A_UNIT) && tempSel;
  wire wrShiftHi = regWr && (regAddr == ISC_A_SHIFT_HI);
  wire wrShiftLo = regWr && (regAddr == ISC_A_SHIFT_LO);
  wire wrScaleHi = regWr && (regAddr == ISC_A_SCALE_HI) && !tempSel;
  wire wrScaleLo = regWr && (regAddr == ISC_A_SCALE_LO) && !tempSel;
  wire wrDecimal = regWr && (regAddr == ISC_A_DECIMAL) && !tempSel
                   && (regWrData <= 32'(ISC_DEC_MAX));
  wire wrOut1 = regWr && (regAddr == ISC_A_OUT1) && iscLegal(ISC_MASK_OUT1, regWrData);
  wire wrOut2 = regWr && (regAddr == ISC_A_OUT2) && iscLegal(ISC_MASK_OUT2, regWrData);
  wire wrAux1 = regWr && (regAddr == ISC_A_AUX1) && iscLegal(ISC_MASK_AUX1, regWrData);
  wire wrAction = regWr && (regAddr == ISC_A_ACTION);
  wire perOk = (regWrData >= 32'(ISC_PERIOD_MIN)) && (regWrData <= 32'(ISC_PERIOD_MAX));
  wire wrPerHeat = regWr && (regAddr == ISC_A_PER_HEAT) && perOk;
  wire wrPerCool = regWr && (regAddr == ISC_A_PER_COOL) && perOk && heatCool;

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      inTypeQ <= ISC_TYPE_RST;
      fahrQ <= ISC_FAHR_RST;
      shiftHiQ <= ISC_SHIFT_RST;
      shiftLoQ <= ISC_SHIFT_RST;
      scaleHiQ <= ISC_SCALE_HI_RST;
      scaleLoQ <= ISC_SCALE_LO_RST;
      decimalQ <= ISC_DEC_RST;
      out1AssignQ <= ISC_OUT1_RST;
      out2AssignQ <= ISC_OUT2_RST;
      aux1AssignQ <= ISC_AUX1_RST;
      reverseQ <= ISC_REVERSE_RST;
      perHeatQ <= ISC_PERIOD_RST;
      perCoolQ <= ISC_PERIOD_RST;
    end else begin
      if (wrType) inTypeQ <= regWrData[4:0];
      if (wrUnit) fahrQ <= regWrData[0];
      if (wrShiftHi) shiftHiQ <= regWrData[15:0];
      if (wrShiftLo) shiftLoQ <= regWrData[15:0];
      if (wrScaleHi) scaleHiQ <= regWrData[15:0];
      if (wrScaleLo) scaleLoQ <= regWrData[15:0];
      if (wrDecimal) decimalQ <= regWrData[1:0];
      if (wrOut1) out1AssignQ <= regWrData[3:0];
      if (wrOut2) out2AssignQ <= regWrData[3:0];
      if (wrAux1) aux1AssignQ <= regWrData[3:0];
      if (wrAction) reverseQ <= regWrData[0];
      if (wrPerHeat) perHeatQ <= regWrData[6:0];
      if (wrPerCool) perCoolQ <= regWrData[6:0];
    end
  end

  // Datapath: sample, then scale one cycle later
  logic [11:0] rawQ;
  logic rawSeenQ;
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      rawQ <= 12'h000;
      rawSeenQ <= 1'b0;
    end else begin
      rawSeenQ <= rawValid && rstSync;
      if (rawValid) rawQ <= rawData;
    end
  end

  wire [15:0] pvSensor = iscLerp(romBus.rangeLo, romBus.rangeHi, rawQ);
  wire [15:0] pvShift = iscLerp(shiftLoQ, shiftHiQ, rawQ);
  wire signed [31:0] pvCel = 32'($signed(pvSensor)) + 32'($signed(pvShift));
  wire signed [31:0] pvFahr = (pvCel * 32'sd9) / 32'sd5 + ISC_F_OFFSET;
  wire [15:0] pvAnalog = iscLerp(scaleLoQ, scaleHiQ, rawQ);
  wire [15:0] pvNext = tempSel ? (fahrQ ? 16'(pvFahr) : 16'(pvCel)) : pvAnalog;
  // Sensors always show tenths; analog uses the stored decimal count
  wire [1:0] dpNext = tempSel ? ISC_TEMP_DP : decimalQ;

  // Error sign follows the action so one clamp serves both sides
  wire signed [31:0] errPv = reverseQ
    ? 32'($signed(setPoint)) - 32'($signed(processValue))
    : 32'($signed(processValue)) - 32'($signed(setPoint));
  wire [6:0] mvHeatNext = iscClamp(errPv);
  wire [6:0] mvCoolNext = heatCool ? iscClamp(-errPv) : 7'h00;

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      processValue <= 16'h0000;
      pvValid <= 1'b0;
      decimalPlaces <= ISC_TEMP_DP;
      fahrenheitOut <= 1'b0;
      heatCoolMode <= 1'b0;
      mvHeat <= 7'h00;
      mvCool <= 7'h00;
    end else begin
      if (rawSeenQ) processValue <= pvNext;
      pvValid <= rawSeenQ;
      decimalPlaces <= dpNext;
      fahrenheitOut <= tempSel && fahrQ;
      heatCoolMode <= heatCool;
      mvHeat <= mvHeatNext;
      mvCool <= mvCoolNext;
    end
  end

  // Time base: 10 ms enable pulse
  logic [31:0] tickCntQ;
  wire tickEn = (tickCntQ == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      tickCntQ <= 32'h0000_0000;
    end else begin
      tickCntQ <= tickEn ? 32'h0000_0000 : tickCntQ + 32'h0000_0001;
    end
  end

  // Period counters in ticks; on-time is period times percent
  logic [13:0] heatSlotQ;
  logic [13:0] coolSlotQ;
  wire [13:0] heatLen = 14'(perHeatQ * 7'(ISC_TICKS_PER_SEC));
  wire [13:0] coolLen = 14'(perCoolQ * 7'(ISC_TICKS_PER_SEC));
  wire heatWrap = (heatSlotQ >= heatLen - 14'h0001);
  wire coolWrap = (coolSlotQ >= coolLen - 14'h0001);
  wire heatOn = heatSlotQ < 14'(perHeatQ * mvHeat);
  wire coolOn = heatCool && (coolSlotQ < 14'(perCoolQ * mvCool));
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      heatSlotQ <= 14'h0000;
      coolSlotQ <= 14'h0000;
    end else if (tickEn) begin
      heatSlotQ <= heatWrap ? 14'h0000 : heatSlotQ + 14'h0001;
      coolSlotQ <= coolWrap ? 14'h0000 : coolSlotQ + 14'h0001;
    end
  end

  // Routing of the twelve functions onto the three outputs
  wire [11:0] fnVec = {funcIn, coolOn, heatOn};
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      ctrlOut1 <= 1'b0;
      ctrlOut2 <= 1'b0;
      auxOut1 <= 1'b0;
    end else begin
      ctrlOut1 <= rstSync && fnVec[out1AssignQ];
      ctrlOut2 <= rstSync && fnVec[out2AssignQ];
      auxOut1 <= rstSync && fnVec[aux1AssignQ];
    end
  end

  // Read mux; scale settings read as zero while hidden
  logic [31:0] rdMux;
  always_comb begin
    case (regAddr)
      ISC_A_TYPE: rdMux = {27'h0, inTypeQ};
      ISC_A_UNIT: rdMux = {31'h0, fahrQ};
      ISC_A_SHIFT_HI: rdMux = {16'h0, shiftHiQ};
      ISC_A_SHIFT_LO: rdMux = {16'h0, shiftLoQ};
      ISC_A_SCALE_HI: rdMux = tempSel ? 32'h0 : {16'h0, scaleHiQ};
      ISC_A_SCALE_LO: rdMux = tempSel ? 32'h0 : {16'h0, scaleLoQ};
      ISC_A_DECIMAL: rdMux = tempSel ? 32'h0 : {30'h0, decimalQ};
      ISC_A_OUT1: rdMux = {28'h0, out1AssignQ};
      ISC_A_OUT2: rdMux = {28'h0, out2AssignQ};
      ISC_A_AUX1: rdMux = {28'h0, aux1AssignQ};
      ISC_A_ACTION: rdMux = {31'h0, reverseQ};
      ISC_A_PER_HEAT: rdMux = {25'h0, perHeatQ};
      ISC_A_PER_COOL: rdMux = heatCool ? {25'h0, perCoolQ} : 32'h0;
      ISC_A_STATUS: rdMux = {30'h0, heatCool, tempSel};
      ISC_A_PV: rdMux = {16'h0, processValue};
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstSync);

  AST_TYPE_RANGE:
    assert property (regWr && regAddr == ISC_A_TYPE && regWrData > 32'(ISC_TYPE_MAX)
                     |=> inTypeQ == $past(inTypeQ))
    else $error("input type took an out-of-range code");

  AST_HIDE_SCALE:
    assert property (regRd && regAddr == ISC_A_SCALE_HI && tempSel |=> regRdData == 32'h0)
    else $error("scale upper setting visible for a sensor type");

  AST_SENSOR_DP:
    assert property (tempSel && $stable(inTypeQ) |=> decimalPlaces == ISC_TEMP_DP)
    else $error("sensor type shows wrong decimal places");

  AST_SCALE_LOCK:
    assert property (tempSel && (regWr && regAddr == ISC_A_SCALE_LO)
                     |=> scaleLoQ == $past(scaleLoQ))
    else $error("scale lower setting changed for a sensor type");

  AST_ROUTE_LEGAL:
    assert property (ISC_MASK_OUT2[out2AssignQ] && ISC_MASK_AUX1[aux1AssignQ]
                     && ISC_MASK_OUT1[out1AssignQ])
    else $error("function routed to a forbidden destination");

  AST_HEAT_COOL:
    assert property (heatCoolMode == $past(heatCool))
    else $error("heat-cool mode does not follow cooling assignment");

  AST_COOL_OFF:
    assert property (!heatCoolMode |-> mvCool == 7'h00)
    else $error("cooling output active with no cooling assignment");

  AST_HEAT_ON:
    assert property (out1AssignQ == ISC_FN_HEAT |=> ctrlOut1 == $past(heatOn))
    else $error("control output 1 does not follow the heating function");

  AST_UNIT_LOCK:
    assert property (regWr && regAddr == ISC_A_UNIT && !tempSel |=> fahrQ == $past(fahrQ))
    else $error("unit setting changed for an analog type");

  AST_DIRECT_ACTION:
    assert property (!reverseQ && $stable(reverseQ) && $signed(processValue) >
                     $signed(setPoint) + 16'sd100 && $stable(processValue) && $stable(setPoint)
                     |=> mvHeat == ISC_MV_FULL)
    else $error("direct action did not drive full output");

  AST_HEAT_WINDOW:
    assert property (tickEn && heatSlotQ == heatLen - 14'h0001 && heatLen != 14'h0000
                     |=> heatSlotQ == 14'h0000)
    else $error("heat period counter did not wrap at period end");

  AST_COOL_PER_LOCK:
    assert property (!heatCool && regWr && regAddr == ISC_A_PER_COOL
                     |=> perCoolQ == $past(perCoolQ))
    else $error("cool period changed with no cooling output");

endmodule

// ### test/isc_sensor_model.sv
// Converter model standing in front of the controller input
`timescale 1ns/1ps
module isc_sensor_model (
  // Clock
  input wire logic clk_sys,
  // Request from the bench
  input wire logic sendReq,
  input wire logic [11:0] sendCode,
  // Converter side
  output logic rawValid,
  output logic [11:0] rawData
);
  logic [11:0] lastCode;

  initial begin
    rawValid = 1'b0;
    rawData = 12'h000;
    lastCode = 12'h000;
  end

  // Code 000 is the lower end of the span, FFF the upper end
  always @(posedge clk_sys) begin
    rawValid <= sendReq;
    if (sendReq) begin
      rawData <= sendCode;
      lastCode <= sendCode;
    end else begin
      // Stale data must not look like the last sample
      rawData <= ~lastCode;
    end
  end
endmodule

// ### test/testbench.sv
// Register, scaling, routing and control checks for the controller core
`timescale 1ns/1ps
module testbench;
  import isc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic rawValid;
  logic [11:0] rawData;
  logic [15:0] setPoint = 16'h0000;
  logic [11:2] funcIn = 10'h000;
  logic [15:0] processValue;
  logic pvValid;
  logic [1:0] decimalPlaces;
  logic fahrenheitOut, heatCoolMode, ctrlOut1, ctrlOut2, auxOut1;
  logic [6:0] mvHeat, mvCool;
  logic sendReq = 1'b0;
  logic [11:0] sendCode = 12'h000;
  int failures = 0;
  int samples_checked = 0;
  int hiCnt;
  int fExp;
  logic signed [15:0] pv, base0, base1;
  localparam logic [7:0] DEF_A [15] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C};
  localparam logic [31:0] DEF_V [15] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h2, 32'h3, 32'h1, 32'h14, 32'h0, 32'h1, 32'h0};
  localparam logic [11:0] RAW [3] = '{12'h800, 12'hFFF, 12'h000};
  localparam logic [15:0] EU [3] = '{16'h041A, 16'h07D0, 16'h0064};

  always #4 clk_sys = ~clk_sys;

  isc_top #(.TICK_CYCLES(4)) isc_top_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rawValid(rawValid),
    .rawData(rawData), .setPoint(setPoint), .funcIn(funcIn), .processValue(processValue),
    .pvValid(pvValid), .decimalPlaces(decimalPlaces), .fahrenheitOut(fahrenheitOut),
    .heatCoolMode(heatCoolMode), .mvHeat(mvHeat), .mvCool(mvCool), .ctrlOut1(ctrlOut1),
    .ctrlOut2(ctrlOut2), .auxOut1(auxOut1)
  );

  isc_sensor_model isc_sensor_model_i (
    .clk_sys(clk_sys), .sendReq(sendReq), .sendCode(sendCode),
    .rawValid(rawValid), .rawData(rawData)
  );

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    // A write stands for a setting made once the mode key has been held
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic chkReg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    // Read data stands only in the cycle after the strobe
    @(negedge clk_sys);
    chkVal(regRdData, exp);
  endtask

  task automatic sample(input logic [11:0] code);
    @(posedge clk_sys);
    sendReq <= 1'b1;
    sendCode <= code;
    @(posedge clk_sys);
    sendReq <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      if (pvValid === 1'b1) break;
    end
    chkVal({31'h0, pvValid}, 32'h1);
    pv = processValue;
    // Let the control outputs follow the new value
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic results;
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < 15; k++) chkReg(DEF_A[k], DEF_V[k]);
    chkVal({30'h0, decimalPlaces}, 32'h1);
    // Short period early, so the tick counter is still inside the new range
    regWrite(ISC_A_PER_HEAT, 32'd1);
    regWrite(ISC_A_PER_HEAT, 32'd0);
    regWrite(ISC_A_PER_HEAT, 32'd100);
    chkReg(ISC_A_PER_HEAT, 32'd1);
    regWrite(ISC_A_TYPE, 32'd22);
    chkReg(ISC_A_TYPE, 32'd2);
    regWrite(ISC_A_TYPE, 32'd21);
    chkReg(ISC_A_TYPE, 32'd21);
    regWrite(ISC_A_TYPE, 32'd17);
    chkReg(ISC_A_STATUS, 32'h0);
    chkReg(ISC_A_SCALE_HI, 32'd1000);
    regWrite(ISC_A_SCALE_HI, 32'd2000);
    regWrite(ISC_A_SCALE_LO, 32'd100);
    regWrite(ISC_A_DECIMAL, 32'd2);
    regWrite(ISC_A_DECIMAL, 32'd4);
    regWrite(ISC_A_UNIT, 32'd1);
    chkReg(ISC_A_DECIMAL, 32'd2);
    chkReg(ISC_A_UNIT, 32'd0);
    chkVal({30'h0, decimalPlaces}, 32'h2);
    @(posedge clk_sys);
    setPoint <= 16'd150;
    for (int k = 0; k < 3; k++) begin
      sample(RAW[k]);
      chkVal({16'h0, pv}, {16'h0, EU[k]});
    end
    chkReg(ISC_A_PV, 32'd100);
    chkVal({25'h0, mvHeat}, 32'd50);
    chkVal({24'h0, heatCoolMode, mvCool}, 32'h0);
    // Half duty over one full one-second period of 100 ticks
    hiCnt = 0;
    repeat (400) begin
      @(negedge clk_sys);
      if (ctrlOut1 === 1'b1) hiCnt++;
    end
    chkVal(32'(hiCnt), 32'd200);
    regWrite(ISC_A_ACTION, 32'd0);
    sample(12'h000);
    chkVal({25'h0, mvHeat}, 32'd0);
    regWrite(ISC_A_PER_COOL, 32'd50);
    chkReg(ISC_A_PER_COOL, 32'd0);
    regWrite(ISC_A_OUT2, 32'd1);
    regWrite(ISC_A_AUX1, 32'd0);
    regWrite(ISC_A_AUX1, 32'd12);
    chkReg(ISC_A_OUT2, 32'd2);
    chkReg(ISC_A_AUX1, 32'd3);
    regWrite(ISC_A_OUT1, 32'd1);
    chkReg(ISC_A_STATUS, 32'h2);
    chkReg(ISC_A_PER_COOL, 32'd20);
    regWrite(ISC_A_PER_COOL, 32'd50);
    chkReg(ISC_A_PER_COOL, 32'd50);
    sample(12'h000);
    chkVal({24'h0, heatCoolMode, mvCool}, 32'h0B2);
    for (int f = 2; f < 12; f++) begin
      regWrite(ISC_A_AUX1, 32'(f));
      funcIn <= 10'(1 << (f - 2));
      repeat (4) @(negedge clk_sys);
      chkVal({30'h0, auxOut1, ctrlOut2}, {30'h0, 1'b1, f == 2});
      @(posedge clk_sys);
      funcIn <= 10'h000;
      repeat (4) @(negedge clk_sys);
      chkVal({30'h0, auxOut1, ctrlOut2}, 32'h0);
    end
    regWrite(ISC_A_TYPE, 32'd2);
    regWrite(ISC_A_SCALE_HI, 32'd5);
    regWrite(ISC_A_SCALE_LO, 32'd7);
    chkReg(ISC_A_SCALE_HI, 32'd0);
    chkVal({30'h0, decimalPlaces}, 32'h1);
    sample(12'h000);
    base0 = pv;
    sample(12'hFFF);
    base1 = pv;
    regWrite(ISC_A_UNIT, 32'd1);
    sample(12'hFFF);
    fExp = (int'(base1) * 9) / 5 + 320;
    chkVal({31'h0, fahrenheitOut}, 32'h1);
    chkVal({16'h0, pv}, {16'h0, 16'(fExp)});
    regWrite(ISC_A_UNIT, 32'd0);
    regWrite(ISC_A_SHIFT_HI, 32'd30);
    regWrite(ISC_A_SHIFT_LO, 32'd10);
    chkReg(ISC_A_SHIFT_HI, 32'd30);
    sample(12'h000);
    chkVal({16'h0, pv}, {16'h0, base0 + 16'sd10});
    sample(12'hFFF);
    chkVal({16'h0, pv}, {16'h0, base1 + 16'sd30});
    results();
  end
endmodule
